// File: bench/frec_seq_model.sv
// Sequencer model that issues operations to the FP control unit and times each answer.
// Assumes one core clock and a one-cycle go request from the bench.
`timescale 1ns/1ps
`default_nettype none
module frec_seq_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        go,
  input  wire logic        op_done,
  input  wire logic        op_executed,
  input  wire logic [31:0] result_out,
  input  wire logic [4:0]  rnd_now,
  output logic             op_valid,
  output logic             busy,
  output logic [7:0]       lat,
  output logic             exe,
  output logic [31:0]      res,
  output logic [4:0]       rnd
);
  logic [7:0] cnt;
  // --------------------
  // Issue and timing
  // --------------------
  // One operation in flight only, because the unit drops issues while it stalls.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op_valid <= 1'b0;
      busy     <= 1'b0;
      cnt      <= 8'h00;
    end else if (go && !busy) begin
      op_valid <= 1'b1;
      busy     <= 1'b1;
      cnt      <= 8'h00;
    end else if (busy) begin
      op_valid <= 1'b0;
      cnt      <= cnt + 8'h01;
      if (cnt == 8'h01) begin
        rnd <= rnd_now;
      end
      if (op_done) begin
        busy <= 1'b0;
        lat  <= cnt;
        exe  <= op_executed;
        res  <= result_out;
      end
    end
  end
endmodule : frec_seq_model
`default_nettype wire

// File: bench/test_float_round_except_ctrl.sv
// Self-checking bench for the FP rounding and exception controller.
// Assumes frec_cfg.svh on the include path and the sequencer model beside it.
`timescale 1ns/1ps
`default_nettype none
`include "frec_cfg.svh"
module test_float_round_except_ctrl;
  // Single-format words: one, two, minus one, zero, a denormal, infinity.
  localparam logic [31:0] ONE = 32'h3f80_0000;
  localparam logic [31:0] TWO = 32'h4000_0000;
  localparam logic [31:0] NEG = 32'hbf80_0000;
  localparam logic [31:0] ZRO = 32'h0000_0000;
  localparam logic [31:0] DEN = 32'h0000_0010;
  localparam logic [31:0] INF = 32'h7f80_0000;
  logic        clk = 1'b0, rst_n = 1'b0, go = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0, prec = 2'h0;
  logic [2:0]  hsize = 3'h2, kind = 3'h0;
  logic [11:0] haddr = 12'h000;
  logic [31:0] hwdata = 32'h0, op_a = 32'h0, op_b = 32'h0, raw_result = 32'h0;
  logic [4:0]  raw = 5'h00;
  logic [3:0]  cnd = 4'h0;
  logic [7:0]  new_ccr = 8'h00;
  logic [31:0] hrdata, result_out, res;
  logic        hreadyout, hresp, op_done, op_executed, round_en_out, irq, op_valid, busy, exe;
  logic [1:0]  round_mode_out, round_prec_out;
  logic [7:0]  condition_code_register, lat, exp_exc, exp_ccr;
  logic [4:0]  rnd;
  logic        ftz_sh;
  logic [31:0] tbl [6] = '{ONE, TWO, NEG, ZRO, DEN, INF};
  int          err_total = 0;
  int          comparisons = 0;

  always #2 clk = ~clk;

  frec_ctrl dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .op_valid(op_valid), .op_is_div(kind[1]),
    .op_is_mul(kind[0]), .op_is_cmp(kind[2]), .op_prec(prec), .op_a(op_a), .op_b(op_b),
    .raw_result(raw_result), .raw_unf(raw[0]), .raw_ovf(raw[1]), .raw_inexact(raw[2]),
    .raw_unordered(raw[3]), .raw_operr(raw[4]), .cond_en(cnd[3]), .cond_is_float(cnd[2]),
    .cond_true(cnd[1]), .cond_update(cnd[0]), .new_ccr(new_ccr), .op_done(op_done),
    .op_executed(op_executed), .result_out(result_out), .round_mode_out(round_mode_out),
    .round_prec_out(round_prec_out), .round_en_out(round_en_out),
    .condition_code_register(condition_code_register), .irq(irq));

  frec_seq_model seq (.clk(clk), .rst_n(rst_n), .go(go), .op_done(op_done),
    .op_executed(op_executed), .result_out(result_out),
    .rnd_now({round_en_out, round_prec_out, round_mode_out}), .op_valid(op_valid),
    .busy(busy), .lat(lat), .exe(exe), .res(res), .rnd(rnd));

  // --------------------
  // Checking and bus tasks
  // --------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  // The master never assumes a latency: it waits for hready until the watchdog ends the run.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do begin @(posedge clk); end while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk); end while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
    if (a == `FREC_OFF_MODE) ftz_sh = d[`FREC_MODE_FTZ_BIT];
    if (a == `FREC_OFF_EXC) exp_exc = d[7:0];
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e, what);
  endtask : rd

  task automatic irq_chk(input logic e);
    repeat (2) @(posedge clk);
    chk(irq, e, "irq");
  endtask : irq_chk

  // --------------------
  // Expected behaviour
  // --------------------
  function automatic int zd(input logic [31:0] v);
    return (v[30:23] == 8'h00) ? 1 : 0;
  endfunction : zd

  function automatic logic [7:0] ev(input logic [2:0] k, input logic [31:0] a, b,
                                    input logic [4:0] f);
    logic az, bz, ai, bi, inv, dz;
    az = a[30:0] == 31'h0;
    bz = b[30:0] == 31'h0;
    ai = a[30:0] == INF[30:0];
    bi = b[30:0] == INF[30:0];
    inv = (k[0] && ((az && bi) || (ai && bz))) || (k[1] && ((az && bz) || (ai && bi)));
    dz = k[1] && bz && !az && !ai;
    return {f[3] & k[2], 2'b00, f[4] | inv, f[1], f[0], dz, f[2]};
  endfunction : ev

  task automatic op(input logic [2:0] k, input logic [31:0] a, b, r, input logic [4:0] f,
                    input logic [3:0] c = 4'h0, input logic [7:0] nc = 8'h00);
    logic run, upd;
    run = !c[3] || c[1];
    upd = run && c[3] && c[0];
    @(posedge clk);
    kind <= k;
    op_a <= a;
    op_b <= b;
    raw_result <= r;
    raw <= f;
    cnd <= c;
    new_ccr <= nc;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do begin @(posedge clk); end while (busy !== 1'b0);
    chk(exe, run, "executed");
    if (run) chk(lat, (ftz_sh || k[2]) ? 1 : 1 + zd(a) + zd(b) + zd(r), "latency");
    if (run) exp_exc = exp_exc | ev(k, a, b, f);
    if (upd) exp_ccr = nc;
    chk(condition_code_register, exp_ccr, "codes");
  endtask : op

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    close_out();
  end

  initial begin
    logic [3:0] c;
    logic [4:0] f;
    exp_exc = 8'h00;
    exp_ccr = 8'h00;
    ftz_sh = 1'b0;
    void'($urandom(32'h0de1));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(`FREC_OFF_MODE, 32'h0, "mode reset");
    rd(`FREC_OFF_EXC, 32'h0, "flags reset");
    wr(12'h020, 32'hffff_ffff);
    rd(12'h020, 32'h0, "unmapped");
    for (int m = 0; m < 4; m++) begin
      wr(`FREC_OFF_MODE, 32'(m));
      prec <= 2'(m % 2);
      rd(`FREC_OFF_MODE, 32'(m), "mode");
      op(3'h0, ONE, TWO, TWO, 5'h04);
      chk(rnd, {1'b1, 2'(m % 2), 2'(m)}, "precision");
      op(3'h4, ONE, TWO, ONE, 5'h00);
      chk(rnd, {3'b010, 2'(m)}, "compare");
    end
    wr(`FREC_OFF_MODE, 32'h4);
    op(3'h1, DEN, ONE, DEN, 5'h05);
    chk(res & 32'h7fff_ffff, 32'h0, "flush");
    wr(`FREC_OFF_MODE, 32'h0);
    op(3'h1, DEN, ONE, DEN, 5'h05);
    chk(res, DEN, "denormal");
    op(3'h0, ZRO, ONE, ONE, 5'h00);
    wr(`FREC_OFF_MODE, 32'h4);
    wr(`FREC_OFF_EXC, 32'h0);
    op(3'h1, ZRO, INF, ONE, 5'h00);
    chk(res, 32'h7fc0_0000, "zero times inf");
    op(3'h2, ZRO, ZRO, ONE, 5'h00);
    chk(res, 32'h7fc0_0000, "zero over zero");
    op(3'h2, INF, INF, ONE, 5'h00);
    chk(res, 32'h7fc0_0000, "inf over inf");
    rd(`FREC_OFF_EXC, 32'h10, "invalid");
    op(3'h2, ONE, ZRO, INF, 5'h00);
    rd(`FREC_OFF_EXC, 32'h12, "div zero");
    foreach (tbl[i]) begin
      c = 4'(24'hfe_ba98 >> (i * 4));
      op(3'h0, ONE, ONE, TWO, 5'h01, c, 8'(i * 37 + 1));
    end
    rd(`FREC_OFF_EXC, {24'h0, exp_exc}, "conditional flags");
    for (int i = 0; i < 60; i++) begin
      if (i % 10 == 0) wr(`FREC_OFF_MODE, 32'($urandom_range(7)));
      f = ($urandom_range(3) == 0) ? 5'($urandom) : 5'h00;
      c = 4'($urandom);
      if (!c[3]) c = 4'h0;
      op(3'($urandom_range(2)), tbl[$urandom_range(5)], tbl[$urandom_range(5)],
         tbl[$urandom_range(5)], f, c, 8'($urandom));
      if (i % 10 == 9) rd(`FREC_OFF_EXC, {24'h0, exp_exc}, "sticky");
      if (i % 20 == 19) wr(`FREC_OFF_EXC, 32'h0);
    end
    wr(`FREC_OFF_EXC, 32'h0);
    op(3'h4, ONE, ONE, ONE, 5'h08);
    op(3'h0, ONE, TWO, TWO, 5'h00);
    rd(`FREC_OFF_EXC, 32'h80, "kept");
    wr(`FREC_OFF_IRQ_STAT, 32'h3);
    irq_chk(1'b0);
    op(3'h0, ONE, ONE, ONE, 5'h02);
    rd(`FREC_OFF_IRQ_STAT, 32'h3, "irq status");
    irq_chk(1'b0);
    wr(`FREC_OFF_IRQ_MASK, 32'h3);
    irq_chk(1'b1);
    wr(`FREC_OFF_IRQ_MASK, 32'h2);
    irq_chk(1'b1);
    wr(`FREC_OFF_IRQ_STAT, 32'h2);
    rd(`FREC_OFF_IRQ_STAT, 32'h1, "irq clear");
    irq_chk(1'b0);
    chk(hresp, 1'b0, "response");
    chk(hreadyout, 1'b1, "ready");
    close_out();
  end
endmodule : test_float_round_except_ctrl
`default_nettype wire

// File: hw/frec_classify.sv
// Classifier for one single-precision operand.
// Assumes IEEE single storage format on the input word.
`timescale 1ns/1ps
`default_nettype none
module frec_classify (
  input  wire logic [31:0] value,
  output logic             is_zero,
  output logic             is_inf,
  output logic             is_nan,
  output logic             is_snan,
  output logic             is_denorm
);
  logic exp_max;
  logic exp_min;
  logic man_zero;
  assign exp_max   = (value[30:23] == 8'hff);
  assign exp_min   = (value[30:23] == 8'h00);
  assign man_zero  = (value[22:0] == 23'h000000);
  assign is_zero   = exp_min && man_zero;
  assign is_inf    = exp_max && man_zero;
  assign is_nan    = exp_max && !man_zero;
  assign is_snan   = is_nan && !value[22];
  assign is_denorm = exp_min;
endmodule : frec_classify
`default_nettype wire

// File: hw/frec_ctrl.sv
// Control part of a 32-bit FP data ALU: underflow mode, exceptions, rounding,
// conditional execution and condition-code update, with an AHB-Lite slave.
// Assumes the sequencer issues one operation at a time and waits for op_done.
`timescale 1ns/1ps
`default_nettype none
`include "frec_cfg.svh"
module frec_ctrl (
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Operation from the sequencer.
  input  wire logic        op_valid,
  input  wire logic        op_is_div,
  input  wire logic        op_is_mul,
  input  wire logic        op_is_cmp,
  input  wire logic [1:0]  op_prec,
  input  wire logic [31:0] op_a,
  input  wire logic [31:0] op_b,
  input  wire logic [31:0] raw_result,
  input  wire logic        raw_unf,
  input  wire logic        raw_ovf,
  input  wire logic        raw_inexact,
  input  wire logic        raw_unordered,
  input  wire logic        raw_operr,
  input  wire logic        cond_en,
  input  wire logic        cond_is_float,
  input  wire logic        cond_true,
  input  wire logic        cond_update,
  input  wire logic [7:0]  new_ccr,
  // Results back to the datapath and sequencer.
  output logic             op_done,
  output logic             op_executed,
  output logic [31:0]      result_out,
  output logic [1:0]       round_mode_out,
  output logic [1:0]       round_prec_out,
  output logic             round_en_out,
  output logic [7:0]       condition_code_register,
  output logic             irq
);
  // ------------------------------------------------------------------
  // Operand classification
  // ------------------------------------------------------------------
  logic a_zero, a_inf, a_nan, a_snan, a_den;
  logic b_zero, b_inf, b_nan, b_snan, b_den;
  logic r_zero, r_inf, r_nan, r_snan, r_den;
  frec_classify u_cls_a (
    .value     (op_a),
    .is_zero   (a_zero),
    .is_inf    (a_inf),
    .is_nan    (a_nan),
    .is_snan   (a_snan),
    .is_denorm (a_den)
  );
  frec_classify u_cls_b (
    .value     (op_b),
    .is_zero   (b_zero),
    .is_inf    (b_inf),
    .is_nan    (b_nan),
    .is_snan   (b_snan),
    .is_denorm (b_den)
  );
  frec_classify u_cls_r (
    .value     (raw_result),
    .is_zero   (r_zero),
    .is_inf    (r_inf),
    .is_nan    (r_nan),
    .is_snan   (r_snan),
    .is_denorm (r_den)
  );

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [31:0]              mode_register;
  logic [`FREC_EXC_W-1:0]   exception_register;
  logic [`FREC_IRQ_W-1:0]   irq_stat_reg;
  logic [`FREC_IRQ_W-1:0]   irq_mask_reg;
  frec_pkg::frec_state_t    state_reg;
  logic [1:0]               stall_cnt_reg;
  logic                     ftz;
  logic                     runs;
  logic                     invalid;
  logic                     div_zero;
  logic [`FREC_EXC_W-1:0]   exc_events;
  logic [1:0]               denorm_count;
  logic [31:0]              fixed_result;

  assign ftz  = mode_register[`FREC_MODE_FTZ_BIT];
  assign runs = !cond_en || cond_true;
  assign invalid = (op_is_mul && ((a_zero && b_inf) || (a_inf && b_zero)))
                 || (op_is_div && ((a_zero && b_zero) || (a_inf && b_inf)));
  assign div_zero = op_is_div && b_zero && !a_zero && !a_nan && !a_inf;
  always_comb begin
    exc_events = '0;
    exc_events[`FREC_EXC_INX]   = raw_inexact;
    exc_events[`FREC_EXC_DZ]    = div_zero;
    exc_events[`FREC_EXC_UNF]   = raw_unf;
    exc_events[`FREC_EXC_OVF]   = raw_ovf;
    exc_events[`FREC_EXC_OPERR] = invalid || raw_operr;
    exc_events[`FREC_EXC_SNAN]  = a_snan || b_snan;
    exc_events[`FREC_EXC_NAN]   = a_nan || b_nan || r_nan;
    exc_events[`FREC_EXC_UNORD] = op_is_cmp && (raw_unordered || a_nan || b_nan);
  end
  // Denormals are counted only in gradual mode; zero counts as denormal.
  always_comb begin
    denorm_count = 2'd0;
    if (!ftz && !op_is_cmp) begin
      denorm_count = 2'({1'b0, a_den} + {1'b0, b_den} + {1'b0, r_den});
    end
  end
  // Defined result for invalid, divide by zero and flushed underflow; no trap is ever taken.
  always_comb begin
    fixed_result = raw_result;
    if (invalid) begin
      fixed_result = 32'h7fc0_0000;
    end else if (div_zero) begin
      fixed_result = {op_a[31] ^ op_b[31], 31'h7f80_0000};
    end else if (ftz && (raw_unf || (r_den && !r_zero))) begin
      fixed_result = {raw_result[31], 31'h0000_0000};
    end
  end

  // ------------------------------------------------------------------
  // Operation sequencing
  // ------------------------------------------------------------------
  logic accept;
  assign accept = op_valid && (state_reg == frec_pkg::FREC_ST_IDLE);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= frec_pkg::FREC_ST_IDLE;
      stall_cnt_reg <= 2'd0;
      op_done       <= 1'b0;
      op_executed   <= 1'b0;
      result_out    <= 32'h0000_0000;
    end else begin
      op_done <= 1'b0;
      unique case (state_reg)
        frec_pkg::FREC_ST_IDLE: begin
          if (accept) begin
            result_out  <= fixed_result;
            op_executed <= runs;
            // Exceptions add nothing; only gradual denormals stall.
            if (runs && denorm_count != 2'd0) begin
              stall_cnt_reg <= denorm_count;
              state_reg     <= frec_pkg::FREC_ST_STALL;
            end else begin
              op_done <= 1'b1;
            end
          end
        end
        frec_pkg::FREC_ST_STALL: begin
          if (stall_cnt_reg == 2'(`FREC_DENORM_CYCLES)) begin
            op_done   <= 1'b1;
            state_reg <= frec_pkg::FREC_ST_IDLE;
          end
          stall_cnt_reg <= stall_cnt_reg - 2'd1;
        end
        default: begin
          state_reg <= frec_pkg::FREC_ST_IDLE;
        end
      endcase
    end
  end

  // Rounding control sent to the datapath, which rounds once from exact.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      round_mode_out <= frec_pkg::FREC_RND_NEAREST;
      round_prec_out <= frec_pkg::FREC_PREC_SINGLE;
      round_en_out   <= 1'b0;
    end else begin
      round_mode_out <= mode_register[`FREC_MODE_RND_LSB +: 2];
      round_prec_out <= op_is_cmp ? frec_pkg::FREC_PREC_NONE : op_prec;
      round_en_out   <= op_valid && !op_is_cmp;
    end
  end

  // ------------------------------------------------------------------
  // AHB-Lite slave
  // ------------------------------------------------------------------
  logic        dp_wr_reg;
  logic        dp_rd_reg;
  logic [11:0] dp_addr_reg;
  logic        ap_valid;
  assign ap_valid = hsel && hready && htrans[1];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dp_wr_reg   <= 1'b0;
      dp_rd_reg   <= 1'b0;
      dp_addr_reg <= 12'h000;
    end else if (hready) begin
      dp_wr_reg   <= ap_valid && hwrite;
      dp_rd_reg   <= ap_valid && !hwrite;
      dp_addr_reg <= haddr;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
  // Read data is registered from the address phase so it stands in the data phase.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_valid && !hwrite) begin
      case (haddr)
        `FREC_OFF_MODE:     hrdata <= mode_register;
        `FREC_OFF_EXC:      hrdata <= {24'h000000, exception_register};
        `FREC_OFF_CCR:      hrdata <= {24'h000000, condition_code_register};
        `FREC_OFF_IRQ_STAT: hrdata <= {30'h0, irq_stat_reg};
        `FREC_OFF_IRQ_MASK: hrdata <= {30'h0, irq_mask_reg};
        `FREC_OFF_STATUS:   hrdata <= {30'h0, state_reg};
        default:            hrdata <= 32'h0000_0000;
      endcase
    end
  end
  logic wr_mode, wr_exc, wr_ccr, wr_istat, wr_imask;
  assign wr_mode  = dp_wr_reg && dp_addr_reg == `FREC_OFF_MODE;
  assign wr_exc   = dp_wr_reg && dp_addr_reg == `FREC_OFF_EXC;
  assign wr_ccr   = dp_wr_reg && dp_addr_reg == `FREC_OFF_CCR;
  assign wr_istat = dp_wr_reg && dp_addr_reg == `FREC_OFF_IRQ_STAT;
  assign wr_imask = dp_wr_reg && dp_addr_reg == `FREC_OFF_IRQ_MASK;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_register <= `FREC_MODE_RESET;
    end else if (wr_mode) begin
      mode_register <= {29'h0, hwdata[2:0]};
    end
  end

  // A new exception in the cycle of a software write still lands.
  logic exc_capture;
  assign exc_capture = accept && runs;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      exception_register <= '0;
    end else begin
      exception_register <= (wr_exc ? hwdata[`FREC_EXC_W-1:0] : exception_register)
                          | (exc_capture ? exc_events : '0);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      condition_code_register <= `FREC_CCR_RESET;
    end else if (accept && runs && cond_en && cond_update) begin
      condition_code_register <= new_ccr;
    end else if (accept && cond_en && !cond_update) begin
      condition_code_register <= condition_code_register;
    end else if (wr_ccr) begin
      condition_code_register <= hwdata[`FREC_CCR_W-1:0];
    end
  end

  // ------------------------------------------------------------------
  // Interrupts
  // ------------------------------------------------------------------
  logic [`FREC_IRQ_W-1:0] irq_ev;
  assign irq_ev = {exc_capture && (exc_events != '0), op_done};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      irq          <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~(wr_istat ? hwdata[`FREC_IRQ_W-1:0] : '0)) | irq_ev;
      if (wr_imask) begin
        irq_mask_reg <= hwdata[`FREC_IRQ_W-1:0];
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_ftz_no_stall: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && ftz) |=> op_done)
    else $error("flush mode operation stalled");
  a_denorm_stall: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && runs && denorm_count == 2'd1) |=> !op_done ##1 op_done)
    else $error("one denormal did not add one cycle");
  a_invalid_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && runs && invalid) |=> exception_register[`FREC_EXC_OPERR])
    else $error("invalid operation not flagged");
  a_invalid_result: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && invalid) |=> result_out == 32'h7fc0_0000)
    else $error("invalid operation result not defined");
  a_sticky_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (exception_register[`FREC_EXC_OVF] && !wr_exc) |=> exception_register[`FREC_EXC_OVF])
    else $error("sticky overflow lost");
  a_divzero_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && runs && div_zero) |=> exception_register[`FREC_EXC_DZ])
    else $error("divide by zero not flagged");
  a_cmp_no_round: assert property (@(posedge clk) disable iff (!rst_n)
    (op_valid && op_is_cmp) |=> !round_en_out && round_prec_out == frec_pkg::FREC_PREC_NONE)
    else $error("compare was rounded");
  a_ccr_keep: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && cond_en && !cond_update) |=> $stable(condition_code_register))
    else $error("codes changed without update");
  a_ccr_update: assert property (@(posedge clk) disable iff (!rst_n)
    (accept && runs && cond_en && cond_update) |=> condition_code_register == $past(new_ccr))
    else $error("codes not updated");
endmodule : frec_ctrl
`default_nettype wire

// File: include/frec_cfg.svh
// Register offsets, field positions, reset values and timing counts for the FP
// rounding and exception controller.
// Assumes a single core clock and a single AHB-Lite slave port.
`ifndef FREC_CFG_SVH
`define FREC_CFG_SVH
`define FREC_OFF_MODE      12'h000
`define FREC_OFF_EXC       12'h004
`define FREC_OFF_CCR       12'h008
`define FREC_OFF_IRQ_STAT  12'h00c
`define FREC_OFF_IRQ_MASK  12'h010
`define FREC_OFF_STATUS    12'h014
`define FREC_MODE_RND_LSB  0
`define FREC_MODE_FTZ_BIT  2
`define FREC_MODE_RESET    32'h0000_0000
`define FREC_EXC_INX       0
`define FREC_EXC_DZ        1
`define FREC_EXC_UNF       2
`define FREC_EXC_OVF       3
`define FREC_EXC_OPERR     4
`define FREC_EXC_SNAN      5
`define FREC_EXC_NAN       6
`define FREC_EXC_UNORD     7
`define FREC_EXC_W         8
`define FREC_CCR_W         8
`define FREC_CCR_RESET     8'h00
`define FREC_IRQ_OP_DONE   0
`define FREC_IRQ_EXC       1
`define FREC_IRQ_W         2
`define FREC_DENORM_CYCLES 1
`endif

// File: include/frec_pkg.sv
// Types shared by the FP rounding and exception controller.
// Assumes frec_cfg.svh is on the include path.
package frec_pkg;
  typedef enum logic [1:0] {
    FREC_RND_NEAREST = 2'b00,
    FREC_RND_ZERO    = 2'b01,
    FREC_RND_PINF    = 2'b10,
    FREC_RND_MINF    = 2'b11
  } frec_rnd_t;
  typedef enum logic [1:0] {
    FREC_PREC_SINGLE = 2'b00,
    FREC_PREC_SEXT   = 2'b01,
    FREC_PREC_NONE   = 2'b10
  } frec_prec_t;
  typedef enum logic [1:0] {
    FREC_ST_IDLE    = 2'b00,
    FREC_ST_STALL   = 2'b01,
    FREC_ST_RESULT  = 2'b10
  } frec_state_t;
endpackage : frec_pkg
